// >>> hdl/jbs_pkg.sv
package jbs_pkg;

  // ----------------------------------------------------------------
  // instruction register defaults
  // ----------------------------------------------------------------
  localparam int IR_LEN = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [1:0] IR_CAPTURE = 2'h1; // low bits loaded at capture

  // ----------------------------------------------------------------
  // identification register layout
  // ----------------------------------------------------------------
  localparam int ID_LEN = 32;
  localparam int ID_MFR_W = 11;
  localparam int ID_PART_W = 16;
  localparam int ID_VER_W = 4;
  localparam logic [10:0] ID_MFR = 11'h2A5; // arbitrary value
  localparam logic [15:0] ID_PART = 16'h1234; // arbitrary value
  localparam logic [3:0] ID_VER = 4'h1; // arbitrary value

  // ----------------------------------------------------------------
  // boundary scan and reset values
  // ----------------------------------------------------------------
  localparam int N_IO = 8;
  localparam int CELLS_PER_IO = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam logic RST_BIT = 1'b0;

  // tap controller states, 4-bit code
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC,
    TAP_PAUSE_IR = 4'hD,
    TAP_EXIT2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } jbs_tap_e;

  // data register control strobes from the tap
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jbs_dr_ctl_s;

endpackage : jbs_pkg

// >>> hdl/jbs_cell.sv
`timescale 1ns/1ps
// one boundary scan cell: shift stage plus update latch
module jbs_cell
(
  input wire logic tck,
  input wire logic trst_n,
  input wire jbs_pkg::jbs_dr_ctl_s ctl,
  input wire logic si,
  input wire logic pi,
  output logic so,
  output logic po
);
  import jbs_pkg::*;

  // ----------------------------------------------------------------
  // serial stage
  // ----------------------------------------------------------------
  // capture parallel input, else shift serial input
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      so <= RST_BIT;
    else if (ctl.capture)
      so <= pi;
    else if (ctl.shift)
      so <= si;
  end

  // ----------------------------------------------------------------
  // parallel stage
  // ----------------------------------------------------------------
  // holds the value while the chain shifts
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      po <= RST_BIT;
    else if (ctl.update)
      po <= so;
  end

endmodule : jbs_cell

// >>> hdl/jbs_tap.sv
`timescale 1ns/1ps
module jbs_tap
#(
  parameter int N_IO = jbs_pkg::N_IO,
  parameter int IR_LEN = jbs_pkg::IR_LEN,
  parameter logic [IR_LEN-1:0] OP_EXTEST = IR_LEN'(jbs_pkg::OP_EXTEST),
  parameter logic [IR_LEN-1:0] OP_SAMPLE = IR_LEN'(jbs_pkg::OP_SAMPLE),
  parameter logic [IR_LEN-1:0] OP_IDCODE = IR_LEN'(jbs_pkg::OP_IDCODE),
  parameter logic [IR_LEN-1:0] OP_BYPASS = IR_LEN'(jbs_pkg::OP_BYPASS),
  parameter int ID_MFR_W = jbs_pkg::ID_MFR_W,
  parameter int ID_PART_W = jbs_pkg::ID_PART_W,
  parameter int ID_VER_W = jbs_pkg::ID_VER_W,
  parameter logic [ID_MFR_W-1:0] ID_MFR = ID_MFR_W'(jbs_pkg::ID_MFR),
  parameter logic [ID_PART_W-1:0] ID_PART = ID_PART_W'(jbs_pkg::ID_PART),
  parameter logic [ID_VER_W-1:0] ID_VER = ID_VER_W'(jbs_pkg::ID_VER)
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic programmed,
  input wire logic [N_IO-1:0] core_out,
  input wire logic [N_IO-1:0] core_oe,
  output logic [N_IO-1:0] core_in,
  input wire logic [N_IO-1:0] pad_in,
  output logic [N_IO-1:0] pad_out,
  output logic [N_IO-1:0] pad_oe,
  output logic io_en
);
  import jbs_pkg::*;

  localparam int NCELL = N_IO * CELLS_PER_IO;
  localparam logic [ID_LEN-1:0] ID_CODE = {ID_VER, ID_PART, ID_MFR, 1'b1};

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (N_IO < 1 || IR_LEN < 2 || ID_VER_W + ID_PART_W + ID_MFR_W + 1 != ID_LEN)
    begin : g_bad_cfg
      $error("jbs_tap: unsupported parameter values");
    end
  endgenerate

  jbs_tap_e state;
  jbs_tap_e next_state;
  logic [IR_LEN-1:0] ir_sh;
  logic [IR_LEN-1:0] ir;
  logic bypass;
  logic [ID_LEN-1:0] id_sh;
  logic sel_bsr;
  logic sel_id;
  logic extest_t;
  logic dr_so;
  jbs_dr_ctl_s bs_ctl;
  logic [NCELL:0] chain;
  logic [NCELL-1:0] cell_pi;
  logic [NCELL-1:0] cell_po;
  logic [N_IO-1:0] upd_out;
  logic [N_IO-1:0] upd_oe;
  logic prog_t1;
  logic prog_t2;
  logic [3*N_IO-1:0] obs_t1;
  logic [3*N_IO-1:0] obs_t2;
  logic ext_c1;
  logic ext_c2;
  logic upd_tog;
  logic tog_c1;
  logic tog_c2;
  logic tog_c3;
  logic [2*N_IO-1:0] upd_c2;
  logic [N_IO-1:0] pin_c1;
  logic [N_IO-1:0] pin_c2;

  // ----------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------
  // next state from tms
  always_comb
  begin
    unique case (state)
      TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // state register, trst forces reset
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      state <= TAP_RESET;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // capture fixed pattern, shift lsb first
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_sh <= '0;
    else if (state == TAP_CAP_IR)
      ir_sh <= IR_LEN'(IR_CAPTURE);
    else if (state == TAP_SHIFT_IR)
      ir_sh <= {tdi, ir_sh[IR_LEN-1:1]};
  end

  // active instruction, idcode after reset
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir <= OP_IDCODE;
    else if (state == TAP_RESET)
      ir <= OP_IDCODE;
    else if (state == TAP_UPD_IR)
      ir <= ir_sh;
  end

  // instruction decode
  assign sel_bsr = (ir == OP_EXTEST) || (ir == OP_SAMPLE);
  assign sel_id = (ir == OP_IDCODE);

  // extest level registered for the crossing
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      extest_t <= 1'b0;
    else
      extest_t <= (ir == OP_EXTEST);
  end

  // update marker for the crossing, updates must lie a few clk apart
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      upd_tog <= 1'b0;
    else if (bs_ctl.update)
      upd_tog <= ~upd_tog;
  end

  // ----------------------------------------------------------------
  // bypass and identification registers
  // ----------------------------------------------------------------
  // bypass captures zero
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bypass <= 1'b0;
    else if (state == TAP_CAP_DR)
      bypass <= 1'b0;
    else if (state == TAP_SHIFT_DR)
      bypass <= tdi;
  end

  // identification shift register
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      id_sh <= '0;
    else if (state == TAP_CAP_DR && sel_id)
      id_sh <= ID_CODE;
    else if (state == TAP_SHIFT_DR && sel_id)
      id_sh <= {tdi, id_sh[ID_LEN-1:1]};
  end

  // ----------------------------------------------------------------
  // boundary scan chain
  // ----------------------------------------------------------------
  // strobes only while a boundary instruction is active
  assign bs_ctl.capture = (state == TAP_CAP_DR) && sel_bsr;
  assign bs_ctl.shift = (state == TAP_SHIFT_DR) && sel_bsr;
  assign bs_ctl.update = (state == TAP_UPD_DR) && sel_bsr;
  assign chain[0] = tdi;

  // pad observation into tck domain
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      prog_t1 <= 1'b0;
      prog_t2 <= 1'b0;
      obs_t1 <= '0;
      obs_t2 <= '0;
    end
    else
    begin
      prog_t1 <= programmed;
      prog_t2 <= prog_t1;
      obs_t1 <= {pad_oe, pad_out, pad_in};
      obs_t2 <= obs_t1;
    end
  end

  // three cells per io: input, output, enable
  generate
    for (genvar i = 0; i < N_IO; i++)
    begin : g_io
      assign cell_pi[CELLS_PER_IO*i+CELL_IN] = obs_t2[i] & prog_t2;
      assign cell_pi[CELLS_PER_IO*i+CELL_OUT] = obs_t2[N_IO+i];
      assign cell_pi[CELLS_PER_IO*i+CELL_OE] = obs_t2[2*N_IO+i];
      assign upd_out[i] = cell_po[CELLS_PER_IO*i+CELL_OUT];
      assign upd_oe[i] = cell_po[CELLS_PER_IO*i+CELL_OE];
      for (genvar k = 0; k < CELLS_PER_IO; k++)
      begin : g_cell
        jbs_cell u_cell
        (
          .tck(tck),
          .trst_n(trst_n),
          .ctl(bs_ctl),
          .si(chain[CELLS_PER_IO*i+k]),
          .pi(cell_pi[CELLS_PER_IO*i+k]),
          .so(chain[CELLS_PER_IO*i+k+1]),
          .po(cell_po[CELLS_PER_IO*i+k])
        );
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // tdo output
  // ----------------------------------------------------------------
  // data register select, bypass by default
  always_comb
  begin
    if (sel_bsr)
      dr_so = chain[NCELL];
    else if (sel_id)
      dr_so = id_sh[0];
    else
      dr_so = bypass;
  end

  // launched on falling tck, enabled in shift states
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo <= (state == TAP_SHIFT_IR) ? ir_sh[0] : dr_so;
      tdo_oe <= (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);
    end
  end

  // ----------------------------------------------------------------
  // pad side, clk domain
  // ----------------------------------------------------------------
  // synchronisers, update word taken once its marker has crossed
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ext_c1 <= 1'b0;
      ext_c2 <= 1'b0;
      tog_c1 <= 1'b0;
      tog_c2 <= 1'b0;
      tog_c3 <= 1'b0;
      upd_c2 <= '0;
      pin_c1 <= '0;
      pin_c2 <= '0;
    end
    else
    begin
      ext_c1 <= extest_t;
      ext_c2 <= ext_c1;
      tog_c1 <= upd_tog;
      tog_c2 <= tog_c1;
      tog_c3 <= tog_c2;
      if (tog_c2 != tog_c3)
        upd_c2 <= {upd_oe, upd_out}; // cells settled since the marker flipped
      pin_c1 <= pad_in;
      pin_c2 <= pin_c1;
    end
  end

  // global enable, pad drive and input buffers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      io_en <= 1'b0;
      pad_out <= '0;
      pad_oe <= '0;
      core_in <= '0;
    end
    else
    begin
      io_en <= programmed;
      pad_out <= {N_IO{programmed}} & (ext_c2 ? upd_c2[N_IO-1:0] : core_out);
      pad_oe <= {N_IO{programmed}} & (ext_c2 ? upd_c2[2*N_IO-1:N_IO] : core_oe);
      core_in <= {N_IO{programmed}} & pin_c2;
    end
  end

endmodule : jbs_tap

// >>> tb/jbs_tap_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------
// port checker for the tap and pad side
// ------------------------------------------------
module jbs_tap_sva
#(
  parameter int N_IO = 8
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic programmed,
  input wire logic [N_IO-1:0] core_out,
  input wire logic [N_IO-1:0] core_oe,
  input wire logic [N_IO-1:0] core_in,
  input wire logic [N_IO-1:0] pad_in,
  input wire logic [N_IO-1:0] pad_out,
  input wire logic [N_IO-1:0] pad_oe,
  input wire logic io_en
);
  // pad side and trst quiet check, clk domain
  a_io_en_lag: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> io_en == $past(programmed)) else $error("io_en lag wrong");
  a_pads_off_unprog: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(programmed) |-> pad_oe == '0 && pad_out == '0) else $error("pad on unprogrammed");
  a_inputs_off_unprog: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(programmed) && !$past(programmed, 2) |-> core_in == '0) else $error("input on");
  a_input_lag: assert property (@(posedge clk) disable iff (!nrst)
    (nrst && programmed)[*5] |-> core_in == $past(pad_in, 3)) else $error("core_in lag wrong");
  a_trst_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !trst_n && !$past(trst_n) |-> !tdo_oe && !tdo) else $error("tdo active in reset");
  // test port, tck domain
  a_oe_after_tms: assert property (@(posedge tck) disable iff (!trst_n)
    $past(tms) |-> !tdo_oe) else $error("tdo_oe outside shift");
  a_shift_entry: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe && !$past(tdo_oe) |-> !$past(tms) && ($past(tms, 2) != $past(tms, 3)))
    else $error("shift entered by a wrong tms walk");
  a_oe_holds_shift: assert property (@(posedge tck) disable iff (!trst_n)
    $past(tdo_oe) && !$past(tms) |-> tdo_oe) else $error("shift left with tms low");
endmodule : jbs_tap_sva

bind jbs_tap jbs_tap_sva #(.N_IO(N_IO)) i_sva (.clk(clk), .nrst(nrst), .tck(tck), .trst_n(trst_n),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .programmed(programmed), .core_out(core_out),
  .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .io_en(io_en));

// >>> tb/jbs_tester.sv
`timescale 1ns/1ps
// ------------------------------------------------
// tester model, tck stands still between steps
// ------------------------------------------------
module jbs_tester
(
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // idle levels, the bench pulses test reset at power-up
  initial
  begin
    tck = 1'h0;
    trst_n = 1'h1;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // one tck period, tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #3;
    q = tdo_oe ? tdo : ~tdo; // undriven tdo has no pull, reads as garbage
    tck = 1'h1;
    #3;
    tck = 1'h0;
  endtask : step
  // test reset pulse with tck stopped, spans two clk edges
  task automatic pulse_trst();
    #2 trst_n = 1'h0;
    #60 trst_n = 1'h1;
    #2;
  endtask : pulse_trst
endmodule : jbs_tester

// >>> tb/jbs_tap_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module jbs_tap_bench;
  import jbs_pkg::*;
  localparam logic [31:0] ID_EXP = {ID_VER, ID_PART, ID_MFR, 1'h1};
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic programmed = 1'h0;
  logic [N_IO-1:0] core_out = 8'h3C;
  logic [N_IO-1:0] core_oe = 8'hF0;
  logic [N_IO-1:0] pad_in = 8'hFF;
  logic tck, trst_n, tms, tdi, tdo, tdo_oe, io_en;
  logic [N_IO-1:0] core_in, pad_out, pad_oe;
  logic [31:0] got;
  int err_count = 0;
  int n_compared = 0;
  // ------------------------------------------------
  // clock, tester and design
  // ------------------------------------------------
  always #12.5 clk = ~clk;
  jbs_tester i_tst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  jbs_tap i_dut (.clk(clk), .nrst(nrst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .programmed(programmed), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .io_en(io_en));
  // one tap step with tdi idle high
  task automatic go(input logic m);
    logic q;
    i_tst.step(m, 1'h1, q);
  endtask : go
  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    go(1'h1);
    if (ir)
      go(1'h1);
    go(1'h0);
    go(1'h0);
    for (int j = 0; j < n; j++)
    begin
      i_tst.step(1'(j == n - 1), din[j], q);
      dout[j] = q;
    end
    go(1'h1);
    go(1'h0);
  endtask : scan
  // power-up and mid-run test reset restore the id path
  task automatic t_reset_id();
    i_tst.pulse_trst();
    go(1'h0);
    scan(1'h0, 32, 32'h0, got);
    `CHK("idcode", ID_EXP, got)
    scan(1'h1, 4, 32'(OP_BYPASS), got);
    i_tst.pulse_trst();
    go(1'h0);
    scan(1'h0, 32, 32'h0, got);
    `CHK("id after trst", ID_EXP, got)
    $display("reset id test done");
  endtask : t_reset_id
  // bypass and an unknown opcode give a one bit path
  task automatic t_bypass();
    logic [3:0] ops [2] = '{OP_BYPASS, 4'h7};
    foreach (ops[k])
    begin
      scan(1'h1, 4, 32'(ops[k]), got);
      `CHK("ir capture", 4'h1, got[3:0])
      scan(1'h0, 8, 32'hB6, got);
      `CHK("bypass", 8'h6C, got[7:0])
    end
    $display("bypass test done");
  endtask : t_bypass
  // five high tms from shift-dr reach reset
  task automatic t_five();
    scan(1'h1, 4, 32'(OP_BYPASS), got);
    go(1'h1);
    go(1'h0);
    go(1'h0);
    #1;
    `CHK("tdo enable in shift", 1'h1, tdo_oe)
    repeat (5) go(1'h1);
    #1;
    `CHK("tdo released", 1'h0, tdo_oe)
    go(1'h0);
    scan(1'h0, 32, 32'h0, got);
    `CHK("id after tms reset", ID_EXP, got)
    $display("tms reset test done");
  endtask : t_five
  // sampling while unprogrammed sees nothing
  task automatic t_sample();
    scan(1'h1, 4, 32'(OP_SAMPLE), got);
    scan(1'h0, 25, 32'h1, got);
    `CHK("sample unprogrammed", 24'h0, got[23:0])
    `CHK("chain length", 1'h1, got[24])
    `CHK("pads off", 8'h0, pad_oe)
    `CHK("pad drive off", 8'h0, pad_out)
    `CHK("inputs off", 8'h0, core_in)
    `CHK("io enable", 1'h0, io_en)
    $display("sample test done");
  endtask : t_sample
  // programmed: normal drive, then boundary drive and capture
  task automatic t_extest();
    logic [23:0] cells;
    logic [23:0] rev;
    logic [23:0] cap;
    @(posedge clk);
    programmed <= 1'h1;
    pad_in <= 8'hA5;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("pad drive", 8'h3C, pad_out)
    `CHK("pad enable", 8'hF0, pad_oe)
    `CHK("core input", 8'hA5, core_in)
    `CHK("io enable on", 1'h1, io_en)
    for (int i = 0; i < N_IO; i++)
      {cells[3 * i + 2], cells[3 * i + 1], cells[3 * i]} = {1'(8'hC3 >> i), 1'(8'h5A >> i), 1'h0};
    rev = {<<{cells}};
    scan(1'h1, 4, 32'(OP_EXTEST), got);
    scan(1'h0, 24, 32'(rev), got);
    cap = {<<{got[23:0]}};
    for (int i = 0; i < N_IO; i++)
      `CHK("input cell", pad_in[i], cap[3 * i])
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("extest drive", 8'h5A, pad_out)
    `CHK("extest enable", 8'hC3, pad_oe)
    $display("extest test done");
  endtask : t_extest
  // verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    t_reset_id();
    t_bypass();
    t_five();
    t_sample();
    t_extest();
    conclude();
  end
  // watchdog, some forty-five times the expected run
  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
endmodule : jbs_tap_bench
